// [design/smap_atr_tx.sv]
`timescale 1ns/10ps
`default_nettype none
module smap_atr_tx (
   // link clock and reset request
   input wire logic link_clk,
   input wire logic rst_req,
   // handshake with reference domain
   input wire logic start,
   output logic done,
   // pin
   input wire logic io_in,
   output logic io_out,
   output logic io_oe_n,
   // answer word, static
   input wire logic [smap_pkg::ATR_W-1:0] atr_word
);

   logic rst_m, rst_l, req_m, req_s, io_m, io_s;
   logic [smap_pkg::ATR_W-1:0] shreg;
   logic [6:0] cnt;
   smap_pkg::smap_tx_e st;

   // ====================================================================
   // synchronisers
   always_ff @(posedge link_clk) begin
      rst_m <= rst_req;
      rst_l <= rst_m;
      req_m <= start;
      req_s <= req_m;
      io_m <= io_in;
      io_s <= io_m;
   end

   // ====================================================================
   // serial answer, msb first, one bit per link clock
   always_ff @(posedge link_clk) begin
      if (rst_l) begin
         st <= smap_pkg::TX_IDLE;
         shreg <= '0;
         cnt <= 7'h00;
         io_out <= 1'b1;
         io_oe_n <= 1'b1;
         done <= 1'b0;
      end else begin
         unique case (st)
            smap_pkg::TX_IDLE: begin
               // start only once the reader releases the line
               if (req_s && io_s) begin
                  st <= smap_pkg::TX_SEND;
                  io_out <= atr_word[smap_pkg::ATR_W-1];
                  shreg <= {atr_word[smap_pkg::ATR_W-2:0], 1'b0};
                  cnt <= 7'h01;
                  io_oe_n <= 1'b0;
               end
            end
            smap_pkg::TX_SEND: begin
               if (cnt == smap_pkg::ATR_BITS) begin
                  st <= smap_pkg::TX_DONE;
                  io_oe_n <= 1'b1;
                  io_out <= 1'b1;
                  done <= 1'b1;
               end else begin
                  io_out <= shreg[smap_pkg::ATR_W-1];
                  shreg <= {shreg[smap_pkg::ATR_W-2:0], 1'b0};
                  cnt <= cnt + 7'h01;
               end
            end
            smap_pkg::TX_DONE: begin
               if (!req_s) begin
                  st <= smap_pkg::TX_IDLE;
                  done <= 1'b0;
               end
            end
         endcase
      end
   end

   // ====================================================================
   // checks
   sequence s_atr_frame;
      ##63 !io_oe_n ##1 io_oe_n;
   endsequence

   AST_ATR_LEN: assert property (@(posedge link_clk) disable iff (rst_l)
      $fell(io_oe_n) |-> s_atr_frame)
      else $error("answer-to-reset not 64 bits long");

   AST_ATR_FIRST: assert property (@(posedge link_clk) disable iff (rst_l)
      $fell(io_oe_n) |-> io_out == atr_word[smap_pkg::ATR_W-1])
      else $error("answer-to-reset first bit wrong");

endmodule
`default_nettype wire

// [design/smap_pkg.sv]
`default_nettype none
// ====================================================================
package smap_pkg;

   // ====================================================================
   // sizes
   localparam int ZONES = 4;
   localparam int ZONE_W = 2;
   localparam int KEY_W = 2;
   localparam int PWD_W = 3;
   localparam int CODE_W = 24;
   localparam int MAC_W = 8;
   localparam int ATR_W = 64;

   // ====================================================================
   // reset values and fixed codes
   localparam logic [CODE_W-1:0] TRANSPORT_CODE_RST = 24'hDD_4297;
   localparam logic [PWD_W-1:0] SUPER_PWD_IDX = 3'h0;
   localparam logic [7:0] MDC_SEED = 8'h00;
   localparam logic [1:0] SAMPLE_WAIT = 2'h2;
   // arbitrary header, low byte is the density code
   localparam logic [ATR_W-1:0] ATR_WORD = 64'h3B00_0000_5A5A_0001;
   localparam logic [6:0] ATR_BITS = 7'h40;

   // ====================================================================
   // command kinds
   localparam logic [2:0] CMD_READ = 3'h0;
   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_VERIFY_PWD = 3'h2;
   localparam logic [2:0] CMD_AUTH = 3'h3;
   localparam logic [2:0] CMD_ENC_ACT = 3'h4;
   localparam logic [2:0] CMD_PRESENT_CODE = 3'h5;
   localparam logic [2:0] CMD_SET_CODE = 3'h6;
   localparam logic [2:0] CMD_READ_MDC = 3'h7;

   // ====================================================================
   // refusal reasons
   localparam logic [2:0] RSN_NONE = 3'h0;
   localparam logic [2:0] RSN_NOT_READY = 3'h1;
   localparam logic [2:0] RSN_MAC = 3'h2;
   localparam logic [2:0] RSN_REVOKED = 3'h3;
   localparam logic [2:0] RSN_ENC = 3'h4;
   localparam logic [2:0] RSN_FORBID = 3'h5;
   localparam logic [2:0] RSN_CFG_LOCK = 3'h6;
   localparam logic [2:0] RSN_DENIED = 3'h7;

   // ====================================================================
   // state types
   typedef enum logic [2:0] {
      MODE_STD = 3'b001,
      MODE_AUTH = 3'b010,
      MODE_ENC = 3'b100
   } smap_mode_e;

   typedef enum logic [4:0] {
      ST_SAMPLE = 5'b00001,
      ST_SYNC_RDY = 5'b00010,
      ST_ASYNC_WAIT = 5'b00100,
      ST_ATR = 5'b01000,
      ST_ASYNC_RDY = 5'b10000
   } smap_start_e;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SEND = 3'b010,
      TX_DONE = 3'b100
   } smap_tx_e;

endpackage
`default_nettype wire

// [design/smap_policy.sv]
`timescale 1ns/10ps
`default_nettype none
module smap_policy (
   // clock and power-up reset
   input wire logic REF_CLK,
   input wire logic RST,
   // link pins
   input wire logic LINK_CLK,
   input wire logic CARD_RST_N,
   input wire logic IO_IN,
   output logic IO_OUT,
   output logic IO_OE_N,
   // zone and option configuration
   input wire logic [smap_pkg::ZONES-1:0] ZONE_ENC_REQ,
   input wire logic [smap_pkg::ZONES-1:0] ZONE_WR_FORBID,
   input wire logic [smap_pkg::ZONES-1:0] ZONE_PGM_ONLY,
   input wire logic [smap_pkg::ZONES*smap_pkg::KEY_W-1:0] ZONE_KEY,
   input wire logic SUPERVISOR_EN,
   // command
   input wire logic CMD_VALID,
   input wire logic [2:0] CMD_KIND,
   input wire logic [smap_pkg::ZONE_W-1:0] CMD_ZONE,
   input wire logic CMD_CFG,
   input wire logic CMD_PWD_AREA,
   input wire logic [smap_pkg::KEY_W-1:0] CMD_KEY,
   input wire logic [smap_pkg::PWD_W-1:0] CMD_PWD_IDX,
   input wire logic CMD_AUTH_OK,
   input wire logic [smap_pkg::MAC_W-1:0] CMD_MESSAGE_AUTH_CODE_HOST,
   input wire logic [smap_pkg::MAC_W-1:0] CMD_MESSAGE_AUTH_CODE_CALC,
   input wire logic [smap_pkg::CODE_W-1:0] CMD_CODE,
   input wire logic [7:0] CMD_OLD_BYTE,
   input wire logic [7:0] CMD_WR_BYTE,
   // response
   output logic RSP_VALID,
   output logic RSP_GRANT,
   output logic [2:0] RSP_REASON,
   output logic RSP_ENCRYPT,
   output logic [7:0] RSP_WR_BYTE,
   output logic [7:0] RSP_MDC,
   // status
   output logic [2:0] MODE,
   output logic PRIV_REVOKED,
   output logic PROTO_ASYNC,
   output logic PROTO_LOCKED,
   output logic LINK_READY,
   output logic CFG_UNLOCKED,
   output logic PWD_ACTIVE,
   output logic [smap_pkg::PWD_W-1:0] PWD_IDX_ACTIVE
);

   smap_pkg::smap_mode_e mode;
   smap_pkg::smap_start_e st;
   logic card_m, card_s, done_m, done_s;
   logic [1:0] sample_cnt;
   logic atr_req, atr_done;
   logic [smap_pkg::KEY_W-1:0] enc_key;
   logic [smap_pkg::CODE_W-1:0] transport_code;
   logic [7:0] mdc;
   logic link_ready, card_reset, exempt, mac_bad, take;
   logic pwd_super, cfg_ok, zone_enc_ok;
   logic next_grant, next_encrypt;
   logic [2:0] next_reason;
   logic [7:0] next_wr_byte;

   // ====================================================================
   // pin and handshake synchronisers
   always_ff @(posedge REF_CLK) begin
      card_m <= CARD_RST_N;
      card_s <= card_m;
      done_m <= atr_done;
      done_s <= done_m;
   end

   // ====================================================================
   // protocol selection at power-up
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         st <= smap_pkg::ST_SAMPLE;
         sample_cnt <= 2'h0;
         PROTO_ASYNC <= 1'b0;
         PROTO_LOCKED <= 1'b0;
         atr_req <= 1'b0;
      end else begin
         unique case (st)
            smap_pkg::ST_SAMPLE: begin
               if (sample_cnt == smap_pkg::SAMPLE_WAIT) begin
                  PROTO_LOCKED <= 1'b1;
                  if (card_s) begin
                     st <= smap_pkg::ST_SYNC_RDY;
                  end else begin
                     st <= smap_pkg::ST_ASYNC_WAIT;
                     PROTO_ASYNC <= 1'b1;
                  end
               end else begin
                  sample_cnt <= sample_cnt + 2'h1;
               end
            end
            smap_pkg::ST_SYNC_RDY: begin
               st <= smap_pkg::ST_SYNC_RDY;
            end
            smap_pkg::ST_ASYNC_WAIT: begin
               // reader raises card reset once its clock has run
               if (card_s) begin
                  st <= smap_pkg::ST_ATR;
                  atr_req <= 1'b1;
               end
            end
            smap_pkg::ST_ATR: begin
               if (done_s) begin
                  st <= smap_pkg::ST_ASYNC_RDY;
                  atr_req <= 1'b0;
               end
            end
            smap_pkg::ST_ASYNC_RDY: begin
               st <= smap_pkg::ST_ASYNC_RDY;
            end
         endcase
      end
   end

   smap_atr_tx u_atr (
      .link_clk(LINK_CLK),
      .rst_req(RST),
      .start(atr_req),
      .done(atr_done),
      .io_in(IO_IN),
      .io_out(IO_OUT),
      .io_oe_n(IO_OE_N),
      .atr_word(smap_pkg::ATR_WORD)
   );

   // ====================================================================
   // command decode
   assign link_ready = (st == smap_pkg::ST_SYNC_RDY) || (st == smap_pkg::ST_ASYNC_RDY);
   // warm card reset drops memorised privileges, protocol stays
   assign card_reset = (st == smap_pkg::ST_ASYNC_RDY) && !card_s;
   assign take = CMD_VALID && link_ready;
   assign exempt = (CMD_KIND == smap_pkg::CMD_AUTH) || (CMD_KIND == smap_pkg::CMD_ENC_ACT);
   assign mac_bad = take && (mode != smap_pkg::MODE_STD) && !exempt &&
                    (CMD_MESSAGE_AUTH_CODE_HOST != CMD_MESSAGE_AUTH_CODE_CALC);
   assign pwd_super = SUPERVISOR_EN && PWD_ACTIVE && (PWD_IDX_ACTIVE == smap_pkg::SUPER_PWD_IDX);
   assign cfg_ok = CFG_UNLOCKED || (CMD_PWD_AREA && pwd_super);
   assign zone_enc_ok = !ZONE_ENC_REQ[CMD_ZONE] ||
                        ((mode == smap_pkg::MODE_ENC) && (enc_key == ZONE_KEY[{CMD_ZONE, 1'b0} +: 2]));

   always_comb begin
      next_grant = 1'b0;
      next_reason = smap_pkg::RSN_NONE;
      next_encrypt = 1'b0;
      next_wr_byte = CMD_WR_BYTE;
      if (!link_ready) begin
         next_reason = smap_pkg::RSN_NOT_READY;
      end else if (mac_bad) begin
         next_reason = smap_pkg::RSN_MAC;
      end else begin
         unique case (CMD_KIND)
            smap_pkg::CMD_READ, smap_pkg::CMD_WRITE: begin
               if (PRIV_REVOKED) begin
                  next_reason = smap_pkg::RSN_REVOKED;
               end else if (CMD_CFG) begin
                  if (!cfg_ok) begin
                     next_reason = smap_pkg::RSN_CFG_LOCK;
                  end else begin
                     next_grant = 1'b1;
                     next_encrypt = CMD_PWD_AREA && (mode != smap_pkg::MODE_STD);
                  end
               end else if (!zone_enc_ok) begin
                  next_reason = smap_pkg::RSN_ENC;
               end else if ((CMD_KIND == smap_pkg::CMD_WRITE) && ZONE_WR_FORBID[CMD_ZONE]) begin
                  next_reason = smap_pkg::RSN_FORBID;
               end else begin
                  next_grant = 1'b1;
                  next_encrypt = (mode == smap_pkg::MODE_ENC);
                  if (ZONE_PGM_ONLY[CMD_ZONE]) begin
                     next_wr_byte = CMD_OLD_BYTE & CMD_WR_BYTE;
                  end
               end
            end
            smap_pkg::CMD_VERIFY_PWD: begin
               next_encrypt = (mode != smap_pkg::MODE_STD);
               if (PRIV_REVOKED) begin
                  next_reason = smap_pkg::RSN_REVOKED;
               end else if (CMD_AUTH_OK) begin
                  next_grant = 1'b1;
               end else begin
                  next_reason = smap_pkg::RSN_DENIED;
               end
            end
            smap_pkg::CMD_AUTH, smap_pkg::CMD_ENC_ACT: begin
               if (CMD_AUTH_OK) begin
                  next_grant = 1'b1;
               end else begin
                  next_reason = smap_pkg::RSN_DENIED;
               end
            end
            smap_pkg::CMD_PRESENT_CODE: begin
               if (CMD_CODE == transport_code) begin
                  next_grant = 1'b1;
               end else begin
                  next_reason = smap_pkg::RSN_DENIED;
               end
            end
            smap_pkg::CMD_SET_CODE: begin
               if (CFG_UNLOCKED) begin
                  next_grant = 1'b1;
               end else begin
                  next_reason = smap_pkg::RSN_CFG_LOCK;
               end
            end
            smap_pkg::CMD_READ_MDC: begin
               next_grant = 1'b1;
            end
         endcase
      end
   end

   // ====================================================================
   // response registers
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         RSP_VALID <= 1'b0;
         RSP_GRANT <= 1'b0;
         RSP_REASON <= smap_pkg::RSN_NONE;
         RSP_ENCRYPT <= 1'b0;
         RSP_WR_BYTE <= 8'h00;
      end else begin
         RSP_VALID <= CMD_VALID;
         RSP_GRANT <= CMD_VALID && next_grant;
         RSP_REASON <= CMD_VALID ? next_reason : smap_pkg::RSN_NONE;
         RSP_ENCRYPT <= CMD_VALID && next_encrypt;
         RSP_WR_BYTE <= next_wr_byte;
      end
   end

   // ====================================================================
   // communication mode and key
   always_ff @(posedge REF_CLK) begin
      if (RST || card_reset) begin
         mode <= smap_pkg::MODE_STD;
         enc_key <= '0;
      end else if (mac_bad) begin
         mode <= smap_pkg::MODE_STD;
      end else if (take && (CMD_KIND == smap_pkg::CMD_AUTH)) begin
         mode <= CMD_AUTH_OK ? smap_pkg::MODE_AUTH : smap_pkg::MODE_STD;
         enc_key <= CMD_KEY;
      end else if (take && (CMD_KIND == smap_pkg::CMD_ENC_ACT)) begin
         mode <= CMD_AUTH_OK ? smap_pkg::MODE_ENC : smap_pkg::MODE_STD;
         enc_key <= CMD_KEY;
      end
   end

   assign MODE = mode;

   // revocation holds until a successful authentication or encryption activation or a warm card reset
   always_ff @(posedge REF_CLK) begin
      if (RST || card_reset) begin
         PRIV_REVOKED <= 1'b0;
      end else if (mac_bad) begin
         PRIV_REVOKED <= 1'b1;
      end else if (take && exempt && CMD_AUTH_OK) begin
         PRIV_REVOKED <= 1'b0;
      end
   end

   // ====================================================================
   // password memory
   always_ff @(posedge REF_CLK) begin
      if (RST || card_reset || mac_bad) begin
         PWD_ACTIVE <= 1'b0;
         PWD_IDX_ACTIVE <= '0;
      end else if (take && (CMD_KIND == smap_pkg::CMD_VERIFY_PWD) && !PRIV_REVOKED) begin
         PWD_ACTIVE <= CMD_AUTH_OK;
         PWD_IDX_ACTIVE <= CMD_PWD_IDX;
      end
   end

   // ====================================================================
   // transport code and configuration gate
   always_ff @(posedge REF_CLK) begin
      if (RST || card_reset) begin
         CFG_UNLOCKED <= 1'b0;
      end else if (take && (CMD_KIND == smap_pkg::CMD_PRESENT_CODE)) begin
         CFG_UNLOCKED <= (CMD_CODE == transport_code) && !mac_bad;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         transport_code <= smap_pkg::TRANSPORT_CODE_RST;
      end else if (take && !mac_bad && (CMD_KIND == smap_pkg::CMD_SET_CODE) && CFG_UNLOCKED) begin
         transport_code <= CMD_CODE;
      end
   end

   // ====================================================================
   // modification detection code over granted writes
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mdc <= smap_pkg::MDC_SEED;
         RSP_MDC <= smap_pkg::MDC_SEED;
      end else if (take && !mac_bad && (CMD_KIND == smap_pkg::CMD_READ_MDC)) begin
         RSP_MDC <= mdc;
         mdc <= smap_pkg::MDC_SEED;
      end else if (take && next_grant && (CMD_KIND == smap_pkg::CMD_WRITE)) begin
         mdc <= {mdc[6:0], mdc[7]} ^ next_wr_byte;
      end
   end

   assign LINK_READY = link_ready;

   // ====================================================================
   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   sequence s_take_bad;
      mac_bad;
   endsequence

   sequence s_refused_mac;
      RSP_VALID && !RSP_GRANT && (RSP_REASON == smap_pkg::RSN_MAC);
   endsequence

   AST_POWERUP_STD: assert property (
      (st == smap_pkg::ST_SAMPLE) |-> (mode == smap_pkg::MODE_STD) && !PRIV_REVOKED)
      else $error("privilege in force before link ready");

   AST_MDC_READ: assert property (
      take && !mac_bad && (CMD_KIND == smap_pkg::CMD_READ_MDC) |=> RSP_GRANT && (RSP_MDC == $past(mdc)))
      else $error("detection code not returned");

   AST_MAC_CHECK: assert property (
      s_take_bad |=> s_refused_mac)
      else $error("code mismatch not refused");

   AST_MAC_REVOKE: assert property (
      s_take_bad |=> (mode == smap_pkg::MODE_STD) && PRIV_REVOKED && !PWD_ACTIVE)
      else $error("privilege kept after code mismatch");

   AST_REVOKED_REFUSE: assert property (
      take && !mac_bad && PRIV_REVOKED && (CMD_KIND == smap_pkg::CMD_READ)
      |=> !RSP_GRANT && (RSP_REASON == smap_pkg::RSN_REVOKED))
      else $error("revoked read granted");

   AST_ENC_DATA: assert property (
      take && next_grant && !CMD_CFG && (CMD_KIND == smap_pkg::CMD_READ) && (mode == smap_pkg::MODE_ENC)
      |=> RSP_ENCRYPT)
      else $error("user data not encrypted");

   AST_ENC_ZONE: assert property (
      take && !CMD_CFG && ZONE_ENC_REQ[CMD_ZONE] && (mode != smap_pkg::MODE_ENC) &&
      ((CMD_KIND == smap_pkg::CMD_READ) || (CMD_KIND == smap_pkg::CMD_WRITE))
      |=> !RSP_GRANT)
      else $error("zone needing encryption accessed in clear");

   AST_ENC_ACT: assert property (
      take && (CMD_KIND == smap_pkg::CMD_ENC_ACT) && CMD_AUTH_OK |=> (mode == smap_pkg::MODE_ENC) && RSP_GRANT)
      else $error("encryption activation failed");

   AST_SUPER: assert property (
      take && !mac_bad && !PRIV_REVOKED && CMD_CFG && CMD_PWD_AREA && pwd_super && (CMD_KIND == smap_pkg::CMD_WRITE)
      |=> RSP_GRANT)
      else $error("supervisor denied password sets");

   AST_FORBID: assert property (
      take && !CMD_CFG && ZONE_WR_FORBID[CMD_ZONE] && (CMD_KIND == smap_pkg::CMD_WRITE) |=> !RSP_GRANT)
      else $error("write to forbidden zone granted");

   AST_PGM_ONLY: assert property (
      take && next_grant && !CMD_CFG && ZONE_PGM_ONLY[CMD_ZONE] && (CMD_KIND == smap_pkg::CMD_WRITE)
      |=> (RSP_WR_BYTE & ~$past(CMD_OLD_BYTE)) == 8'h00 && RSP_WR_BYTE == ($past(CMD_OLD_BYTE) & $past(CMD_WR_BYTE)))
      else $error("program-only zone bit raised");

   AST_PROTO_HOLD: assert property (
      PROTO_LOCKED |=> PROTO_LOCKED && $stable(PROTO_ASYNC))
      else $error("protocol changed within power cycle");

   AST_PROTO_SYNC: assert property (
      (st == smap_pkg::ST_SAMPLE) && (sample_cnt == smap_pkg::SAMPLE_WAIT) && card_s |=> !PROTO_ASYNC && LINK_READY)
      else $error("synchronous default not taken");

   AST_CFG_LOCK: assert property (
      take && !mac_bad && CMD_CFG && !CFG_UNLOCKED && !CMD_PWD_AREA && (CMD_KIND == smap_pkg::CMD_READ) |=> !RSP_GRANT)
      else $error("configuration read before transport code");

   AST_SET_CODE: assert property (
      take && !mac_bad && CFG_UNLOCKED && (CMD_KIND == smap_pkg::CMD_SET_CODE) |=> transport_code == $past(CMD_CODE))
      else $error("transport code not replaced");

endmodule
`default_nettype wire

// [testbench/smap_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// =========
// reader at the link
module smap_host_model (
   // link
   output logic link_clk,
   output logic card_rst_n,
   output logic io_in,
   input wire logic io_out,
   input wire logic io_oe_n,
   // control and capture
   input wire logic cold,
   output logic [63:0] rx
);
   int cnt = 0;
   initial begin
      link_clk = 1'b0;
      #37;
      forever #40 link_clk = ~link_clk;
   end
   always @(posedge link_clk) begin
      if (!cold) cnt <= 0;
      else if (cnt < 400) cnt <= cnt + 1;
   end
   assign card_rst_n = !cold || cnt == 400;
   // pull-up on the data line
   assign io_in = io_oe_n ? 1'b1 : io_out;
   always @(negedge link_clk) begin
      if (!io_oe_n) rx <= {rx[62:0], io_out};
   end
endmodule
`default_nettype wire

// [testbench/smap_policy_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// =========
// bench
module smap_policy_tb;
   logic ref_clk, rst, lk, crn, ii, io, oe, cold, sup, cv, cfg, pa, ok, rv, gr, enc, pr, pas, pl, lr, cu, pw;
   logic [2:0] kind, pidx, rsn, mode, pwi;
   logic [1:0] zone, key;
   logic [7:0] mh, mc, ob, wb, wr, mdc;
   logic [23:0] code;
   logic [63:0] rx;
   int n_errors = 0;
   int checked = 0;
   smap_host_model smap_host_model_i (.link_clk(lk), .card_rst_n(crn), .io_in(ii), .io_out(io), .io_oe_n(oe),
      .cold(cold), .rx(rx));
   smap_policy smap_policy_i (.REF_CLK(ref_clk), .RST(rst), .LINK_CLK(lk), .CARD_RST_N(crn), .IO_IN(ii),
      .IO_OUT(io), .IO_OE_N(oe), .ZONE_ENC_REQ(4'h4), .ZONE_WR_FORBID(4'h2), .ZONE_PGM_ONLY(4'h1),
      .ZONE_KEY(8'h00), .SUPERVISOR_EN(sup), .CMD_VALID(cv), .CMD_KIND(kind), .CMD_ZONE(zone), .CMD_CFG(cfg),
      .CMD_PWD_AREA(pa), .CMD_KEY(key), .CMD_PWD_IDX(pidx), .CMD_AUTH_OK(ok), .CMD_MESSAGE_AUTH_CODE_HOST(mh),
      .CMD_MESSAGE_AUTH_CODE_CALC(mc), .CMD_CODE(code), .CMD_OLD_BYTE(ob), .CMD_WR_BYTE(wb), .RSP_VALID(rv),
      .RSP_GRANT(gr), .RSP_REASON(rsn), .RSP_ENCRYPT(enc), .RSP_WR_BYTE(wr), .RSP_MDC(mdc), .MODE(mode),
      .PRIV_REVOKED(pr), .PROTO_ASYNC(pas), .PROTO_LOCKED(pl), .LINK_READY(lr), .CFG_UNLOCKED(cu),
      .PWD_ACTIVE(pw), .PWD_IDX_ACTIVE(pwi));
   task automatic give_verdict;
      if (n_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cmd(input logic [2:0] k, input logic [1:0] z);
      @(negedge ref_clk);
      kind = k;
      zone = z;
      cv = 1'b1;
      @(negedge ref_clk);
      cv = 1'b0;
      for (int i = 0; i < 3 && rv !== 1'b1; i++) @(negedge ref_clk);
      if (rv !== 1'b1) begin
         n_errors++;
         give_verdict();
      end
   endtask
   task automatic t_zones;
      chk("mode", {pl, pas, mode}, 5'h11);
      ob = 8'hF0;
      wb = 8'h3C;
      cmd(smap_pkg::CMD_WRITE, 2'h0);
      chk("wr", wr, 8'h30);
      cmd(smap_pkg::CMD_WRITE, 2'h1);
      chk("rsn", rsn, smap_pkg::RSN_FORBID);
      cmd(smap_pkg::CMD_READ_MDC, 2'h0);
      chk("mdc", mdc, 8'h30);
      cmd(smap_pkg::CMD_READ, 2'h2);
      chk("rsn", rsn, smap_pkg::RSN_ENC);
   endtask
   task automatic t_mac;
      ok = 1'b1;
      key = 2'h1;
      cmd(smap_pkg::CMD_ENC_ACT, 2'h0);
      cmd(smap_pkg::CMD_READ, 2'h2);
      chk("key", {mode, rsn}, {3'h4, smap_pkg::RSN_ENC});
      key = 2'h0;
      cmd(smap_pkg::CMD_ENC_ACT, 2'h0);
      chk("mode", mode, 3'h4);
      cmd(smap_pkg::CMD_READ, 2'h2);
      chk("enc", {gr, enc}, 2'h3);
      mh = 8'h01;
      cmd(smap_pkg::CMD_READ, 2'h2);
      chk("rsn", {rsn, pr, mode}, {smap_pkg::RSN_MAC, 4'h9});
      mh = 8'h00;
      cmd(smap_pkg::CMD_READ, 2'h0);
      chk("rsn", rsn, smap_pkg::RSN_REVOKED);
      cmd(smap_pkg::CMD_ENC_ACT, 2'h0);
      chk("rev", pr, 1'b0);
      ok = 1'b0;
      cmd(smap_pkg::CMD_AUTH, 2'h0);
      chk("auth", {rsn, mode}, {smap_pkg::RSN_DENIED, 3'h1});
      ok = 1'b1;
      cmd(smap_pkg::CMD_AUTH, 2'h0);
      chk("auth", {gr, mode}, 4'ha);
   endtask
   task automatic t_cfg;
      cfg = 1'b1;
      cmd(smap_pkg::CMD_READ, 2'h0);
      chk("rsn", rsn, smap_pkg::RSN_CFG_LOCK);
      code = smap_pkg::TRANSPORT_CODE_RST;
      cmd(smap_pkg::CMD_PRESENT_CODE, 2'h0);
      chk("unl", cu, 1'b1);
      code = 24'h12_3456;
      cmd(smap_pkg::CMD_SET_CODE, 2'h0);
      cmd(smap_pkg::CMD_PRESENT_CODE, 2'h0);
      chk("unl", cu, 1'b1);
      code = smap_pkg::TRANSPORT_CODE_RST;
      cmd(smap_pkg::CMD_PRESENT_CODE, 2'h0);
      chk("unl", cu, 1'b0);
      sup = 1'b1;
      pa = 1'b1;
      cmd(smap_pkg::CMD_VERIFY_PWD, 2'h0);
      chk("pwd", {pw, pwi}, 4'h8);
      cmd(smap_pkg::CMD_WRITE, 2'h0);
      chk("gr", gr, 1'b1);
   endtask
   task automatic t_async;
      cold = 1'b1;
      rst = 1'b1;
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 3000 && lr !== 1'b1; i++) @(negedge ref_clk);
      if (lr !== 1'b1) begin
         n_errors++;
         give_verdict();
      end
      chk("atr", rx, smap_pkg::ATR_WORD);
      cold = 1'b0;
      repeat (3) @(negedge ref_clk);
      cold = 1'b1;
      repeat (9) @(negedge ref_clk);
      chk("async", {lr, pas}, 2'h3);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      rst = 1'b1;
      {cv, cold, sup, ok, cfg, pa, kind, zone, pidx} = 14'h0000;
      {mh, mc, ob, wb, code} = 56'h0000;
      key = 2'h0;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      repeat (5) @(negedge ref_clk);
      repeat (5) @(posedge lk);
      @(negedge ref_clk);
      t_zones();
      t_mac();
      t_cfg();
      t_async();
      give_verdict();
   end
endmodule
`default_nettype wire
